// ---- hdl/startup_regs.svh ----
// Register map, field positions, codes and timing constants of the start-up block
// Overview of operation
// - Identification register upper nibble reads the fixed major revision code.
// - Identification register lower nibble reads the fixed minor revision code.
// - Supply monitor holds reset until supply is good; release starts configuration load.
// - Normal operation starts a fixed delay after reset release, covering configuration.
// - Two-bit start-up field selects relative, reserved, absolute or burst behaviour.
// - Relative mode keeps both quadrature outputs low through start-up.
// - Absolute mode drives quadrature levels from absolute position within the period.
// - Absolute mode uses the index phase offset register for quadrature-to-index phase.
// - Burst mode emits quadrature transitions stepping from zero toward the absolute position, shortest way round.
// - Start-up mode default is loaded from the nonvolatile configuration word.
// - While the halt bit is set, quadrature and index generation stops.
// - Clearing the halt bit restarts generation following the selected start-up mode.
// - Halt never blocks serial port accesses or register bank traffic.
// - Halt bit is stored nonvolatile; host may set it during reconfiguration.
// - Every register bank location is eight bits wide; location 0 reads identification, locations 1 and 2 hold chip controls.
// - Every nonvolatile location is thirty-two bits wide.
// - Nonvolatile locations five to seven hold free user data.
// - Neither serial port has a timeout; partial frames wait for more clocks.
// - Two-wire port: host drives shift clock, one shared bidirectional data line.
// - Two-wire port reads all registers, writes all but fixed location 0, and reads and writes the nonvolatile store.
// - One-wire port only writes register and nonvolatile banks, never returns data.
// - Start bit then 00 selects register write of eight data bits.
// - Start bit then 10 selects register read, one idle turnaround clock first.
// - Register address field is five bits, top bit always zero.
`ifndef STARTUP_REGS_SVH
`define STARTUP_REGS_SVH
`define REG_ID_ADDR 4'h0
`define REG_STARTUP_ADDR 4'h1
`define REG_INDEX_PHASE_ADDR 4'h2
`define REG_COUNT 16
`define MODE_MSB 4
`define MODE_LSB 3
`define HALT_BIT 6
`define MODE_RELATIVE 2'h0
`define MODE_RESERVED 2'h1
`define MODE_ABSOLUTE 2'h2
`define MODE_BURST 2'h3
`define EE_CONFIG_ADDR 3'h0
`define EE_COUNT 8
`define CFG_STARTUP_LSB 0
`define CFG_PHASE_LSB 8
`define CMD_SHORT_LAST 6'h01
`define CMD_LONG_LAST 6'h03
`define REG_ADDR_LAST 6'h04
`define EE_ADDR_LAST 6'h02
`define REG_DATA_LAST 6'h07
`define EE_DATA_LAST 6'h1f
`define CLK_PERIOD_NS 8
`define STARTUP_DELAY_MS 20
`define STEP_PERIOD_NS 80
`define ONE_WIRE_ONE_MIN_NS 2000
`endif

// ---- hdl/startup_pkg.sv ----
// Types shared by the start-up and configuration block
package startup_pkg;
    typedef enum logic [3:0] {
        SEQ_HOLD = 4'h1,
        SEQ_LOAD = 4'h2,
        SEQ_WAIT = 4'h4,
        SEQ_RUN = 4'h8
    } seq_state_t;
    typedef enum logic [6:0] {
        FRAME_IDLE = 7'h01,
        FRAME_CMD = 7'h02,
        FRAME_ADDR = 7'h04,
        FRAME_TURN = 7'h08,
        FRAME_WDATA = 7'h10,
        FRAME_RDATA = 7'h20,
        FRAME_TRAIL = 7'h40
    } frame_state_t;
endpackage

// ---- hdl/nv_store.sv ----
// Nonvolatile configuration and user data store
`timescale 1ns/100ps
`default_nettype none
`include "startup_regs.svh"
module nv_store #(
    parameter logic [31:0] DEFAULT_CONFIG_WORD = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic write_en,
    input wire logic [2:0] write_addr,
    input wire logic [31:0] write_data,
    input wire logic [2:0] read_addr,
    output logic [31:0] read_data
);
    logic [31:0] mem [0:`EE_COUNT-1];

    // Contents survive reset; initial image stands for the programmed state
    initial begin
        for (int i = 0; i < `EE_COUNT; i++) begin
            mem[i] = (i == 0) ? DEFAULT_CONFIG_WORD : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (write_en) begin
            mem[write_addr] <= write_data;
        end
    end

    always_ff @(posedge clk) begin
        read_data <= mem[read_addr];
    end
endmodule // nv_store
`default_nettype wire

// ---- hdl/serial_frame_decoder.sv ----
// Bit-level frame decoder shared by the two-wire and one-wire ports
`timescale 1ns/100ps
`default_nettype none
`include "startup_regs.svh"
module serial_frame_decoder
    import startup_pkg::*;
#(
    parameter bit ALLOW_READ = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_strobe,
    input wire logic bit_value,
    input wire logic shift_strobe,
    input wire logic [31:0] read_data,
    output logic reg_write,
    output logic ee_write,
    output logic read_request,
    output logic ee_access,
    output logic [4:0] addr,
    output logic [31:0] write_data,
    output logic out_bit,
    output logic out_enable
);
    frame_state_t state;
    logic [5:0] count;
    logic [2:0] cmd;
    logic is_read;
    logic cmd_ok;
    logic [31:0] shifter;
    logic addr_last;
    logic data_last;

    assign addr_last = (count == (ee_access ? `EE_ADDR_LAST : `REG_ADDR_LAST));
    assign data_last = (count == (ee_access ? `EE_DATA_LAST : `REG_DATA_LAST));

    // No timeout anywhere: state only moves on a bit strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= FRAME_IDLE;
            count <= 6'h00;
            cmd <= 3'h0;
            is_read <= 1'b0;
            cmd_ok <= 1'b0;
            ee_access <= 1'b0;
            shifter <= 32'h0000_0000;
            addr <= 5'h00;
        end else if (bit_strobe) begin
            unique case (state)
                FRAME_IDLE: begin
                    if (bit_value) begin
                        state <= FRAME_CMD;
                        count <= 6'h00;
                    end
                end
                FRAME_CMD: begin
                    cmd <= {cmd[1:0], bit_value};
                    count <= count + 6'h01;
                    if (count == `CMD_SHORT_LAST && !bit_value) begin
                        ee_access <= 1'b0;
                        is_read <= cmd[0];
                        cmd_ok <= 1'b1;
                        state <= FRAME_ADDR;
                        count <= 6'h00;
                    end else if (count == `CMD_LONG_LAST) begin
                        ee_access <= 1'b1;
                        is_read <= cmd[2];
                        cmd_ok <= !(cmd[0] | bit_value);
                        state <= FRAME_ADDR;
                        count <= 6'h00;
                    end
                end
                FRAME_ADDR: begin
                    shifter <= {shifter[30:0], bit_value};
                    count <= count + 6'h01;
                    if (addr_last) begin
                        addr <= ee_access ? {2'h0, shifter[1:0], bit_value} : {shifter[3:0], bit_value};
                        count <= 6'h00;
                        if (!is_read) begin
                            state <= FRAME_WDATA;
                        end else if (cmd_ok && ALLOW_READ) begin
                            state <= FRAME_TURN;
                        end else begin
                            state <= FRAME_TRAIL;
                        end
                    end
                end
                FRAME_TURN: begin
                    shifter <= ee_access ? read_data : {read_data[7:0], 24'h00_0000};
                    state <= FRAME_RDATA;
                end
                FRAME_WDATA: begin
                    shifter <= {shifter[30:0], bit_value};
                    count <= count + 6'h01;
                    if (data_last) begin
                        state <= FRAME_TRAIL;
                    end
                end
                FRAME_RDATA: begin
                    shifter <= {shifter[30:0], 1'b0};
                    count <= count + 6'h01;
                    if (data_last) begin
                        state <= FRAME_TRAIL;
                    end
                end
                FRAME_TRAIL: begin
                    if (!bit_value) begin
                        state <= FRAME_IDLE;
                    end
                end
                default: begin
                    state <= FRAME_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_write <= 1'b0;
            ee_write <= 1'b0;
            read_request <= 1'b0;
            write_data <= 32'h0000_0000;
        end else begin
            reg_write <= bit_strobe && state == FRAME_WDATA && data_last && !ee_access;
            ee_write <= bit_strobe && state == FRAME_WDATA && data_last && ee_access && cmd_ok;
            read_request <= bit_strobe && state == FRAME_ADDR && addr_last && is_read && cmd_ok && ALLOW_READ;
            if (bit_strobe && state == FRAME_WDATA && data_last) begin
                write_data <= {shifter[30:0], bit_value};
            end
        end
    end

    // Data goes out after the rising clock edge, released after the last sample
    always_ff @(posedge clk) begin
        if (!rst_n || !ALLOW_READ || state != FRAME_RDATA) begin
            out_bit <= 1'b0;
            out_enable <= 1'b0;
        end else if (bit_strobe && data_last) begin
            out_enable <= 1'b0;
        end else if (shift_strobe) begin
            out_bit <= shifter[31];
            out_enable <= 1'b1;
        end
    end
endmodule // serial_frame_decoder
`default_nettype wire

// ---- hdl/startup_config_and_id.sv ----
// Start-up sequencing, configuration load, register bank, serial ports and A/B/Z start-up control
`timescale 1ns/100ps
`default_nettype none
`include "startup_regs.svh"
module startup_config_and_id
    import startup_pkg::*;
#(
    // Identification nibbles: arbitrary neutral values
    parameter logic [3:0] MAJOR_REVISION = 4'h1,
    parameter logic [3:0] MINOR_REVISION = 4'h0,
    parameter logic [31:0] DEFAULT_CONFIG_WORD = 32'h0000_0000,
    parameter int STARTUP_DELAY_CYCLES = `STARTUP_DELAY_MS * 1000000 / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic external_reset_pin_n,
    input wire logic supply_ok,
    input wire logic serial_clock,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    input wire logic one_wire_line,
    input wire logic [7:0] sensor_position,
    output logic quad_a,
    output logic quad_b,
    output logic index_z,
    output logic normal_operation
);
    localparam int STEP_CYCLES = (`STEP_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int ONE_WIRE_ONE_CYCLES = (`ONE_WIRE_ONE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // Pin synchronisers
    logic [1:0] supply_sync;
    logic [1:0] ext_reset_sync;
    logic [1:0] sclk_sync;
    logic [1:0] serial_data_line_sync;
    logic [1:0] one_wire_sync;
    logic sclk_prev;
    logic one_wire_prev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            supply_sync <= 2'h0;
            ext_reset_sync <= 2'h0;
            sclk_sync <= 2'h0;
            serial_data_line_sync <= 2'h0;
            one_wire_sync <= 2'h0;
            sclk_prev <= 1'b0;
            one_wire_prev <= 1'b0;
        end else begin
            supply_sync <= {supply_sync[0], supply_ok};
            ext_reset_sync <= {ext_reset_sync[0], external_reset_pin_n};
            sclk_sync <= {sclk_sync[0], serial_clock};
            serial_data_line_sync <= {serial_data_line_sync[0], serial_data_line_in};
            one_wire_sync <= {one_wire_sync[0], one_wire_line};
            sclk_prev <= sclk_sync[1];
            one_wire_prev <= one_wire_sync[1];
        end
    end

    logic sclk_fall;
    logic sclk_rise;
    logic one_wire_fall;
    logic device_hold;

    assign sclk_fall = sclk_prev && !sclk_sync[1];
    assign sclk_rise = !sclk_prev && sclk_sync[1];
    assign one_wire_fall = one_wire_prev && !one_wire_sync[1];
    assign device_hold = !supply_sync[1] || !ext_reset_sync[1];

    // One-wire bits are pulse widths; the counter saturates instead of timing out
    logic [15:0] high_count;
    logic one_wire_bit;

    always_ff @(posedge clk) begin
        if (!rst_n || !one_wire_sync[1]) begin
            high_count <= 16'h0000;
        end else if (high_count != 16'hffff) begin
            high_count <= high_count + 16'h0001;
        end
    end

    assign one_wire_bit = (high_count >= 16'(ONE_WIRE_ONE_CYCLES));

    // Serial ports
    logic [31:0] tw_read_data;
    logic tw_reg_write;
    logic tw_ee_write;
    logic tw_ee_access;
    logic [4:0] tw_addr;
    logic [31:0] tw_write_data;
    logic ow_reg_write;
    logic ow_ee_write;
    logic [4:0] ow_addr;
    logic [31:0] ow_write_data;

    serial_frame_decoder #(
        .ALLOW_READ(1'b1)
    ) two_wire_port (
        .clk(clk),
        .rst_n(rst_n),
        .bit_strobe(sclk_fall),
        .bit_value(serial_data_line_sync[1]),
        .shift_strobe(sclk_rise),
        .read_data(tw_read_data),
        .reg_write(tw_reg_write),
        .ee_write(tw_ee_write),
        .read_request(),
        .ee_access(tw_ee_access),
        .addr(tw_addr),
        .write_data(tw_write_data),
        .out_bit(serial_data_line_out),
        .out_enable(serial_data_line_oe)
    );

    serial_frame_decoder #(
        .ALLOW_READ(1'b0)
    ) one_wire_port (
        .clk(clk),
        .rst_n(rst_n),
        .bit_strobe(one_wire_fall),
        .bit_value(one_wire_bit),
        .shift_strobe(1'b0),
        .read_data(32'h0000_0000),
        .reg_write(ow_reg_write),
        .ee_write(ow_ee_write),
        .read_request(),
        .ee_access(),
        .addr(ow_addr),
        .write_data(ow_write_data),
        .out_bit(),
        .out_enable()
    );

    // Start-up sequencer
    seq_state_t seq_state;
    logic [31:0] delay_count;
    logic load_wait;
    logic load_capture;
    logic [31:0] nv_read_data;

    assign load_capture = (seq_state == SEQ_LOAD) && load_wait;

    always_ff @(posedge clk) begin
        if (!rst_n || device_hold) begin
            seq_state <= SEQ_HOLD;
            delay_count <= 32'h0000_0000;
            load_wait <= 1'b0;
        end else begin
            if (seq_state != SEQ_RUN) begin
                delay_count <= delay_count + 32'h0000_0001;
            end
            unique case (seq_state)
                SEQ_HOLD: begin
                    seq_state <= SEQ_LOAD;
                    load_wait <= 1'b0;
                end
                SEQ_LOAD: begin
                    load_wait <= 1'b1;
                    if (load_wait) begin
                        seq_state <= SEQ_WAIT;
                    end
                end
                SEQ_WAIT: begin
                    if (delay_count >= 32'(STARTUP_DELAY_CYCLES - 1)) begin
                        seq_state <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    seq_state <= SEQ_RUN;
                end
                default: begin
                    seq_state <= SEQ_HOLD;
                end
            endcase
        end
    end

    assign normal_operation = (seq_state == SEQ_RUN);

    // Nonvolatile store; the two-wire port wins a same-cycle write
    logic nv_write_en;
    logic [2:0] nv_write_addr;
    logic [31:0] nv_write_data;
    logic [2:0] nv_read_addr;

    assign nv_write_en = tw_ee_write || ow_ee_write;
    assign nv_write_addr = tw_ee_write ? tw_addr[2:0] : ow_addr[2:0];
    assign nv_write_data = tw_ee_write ? tw_write_data : ow_write_data;
    assign nv_read_addr = (seq_state == SEQ_LOAD) ? `EE_CONFIG_ADDR : tw_addr[2:0];

    nv_store #(
        .DEFAULT_CONFIG_WORD(DEFAULT_CONFIG_WORD)
    ) config_store (
        .clk(clk),
        .write_en(nv_write_en),
        .write_addr(nv_write_addr),
        .write_data(nv_write_data),
        .read_addr(nv_read_addr),
        .read_data(nv_read_data)
    );

    // Register bank: one byte per location, location 0 fixed
    logic [7:0] reg_bank [0:`REG_COUNT-1];

    assign reg_bank[0] = {MAJOR_REVISION, MINOR_REVISION};

    for (genvar i = 1; i < `REG_COUNT; i++) begin : gen_reg
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                reg_bank[i] <= 8'h00;
            end else if (tw_reg_write && tw_addr[3:0] == 4'(i)) begin
                reg_bank[i] <= tw_write_data[7:0];
            end else if (ow_reg_write && ow_addr[3:0] == 4'(i)) begin
                reg_bank[i] <= ow_write_data[7:0];
            end else if (load_capture && 4'(i) == `REG_STARTUP_ADDR) begin
                reg_bank[i] <= nv_read_data[`CFG_STARTUP_LSB +: 8];
            end else if (load_capture && 4'(i) == `REG_INDEX_PHASE_ADDR) begin
                reg_bank[i] <= nv_read_data[`CFG_PHASE_LSB +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tw_read_data <= 32'h0000_0000;
        end else if (tw_ee_access) begin
            tw_read_data <= nv_read_data;
        end else begin
            tw_read_data <= {24'h00_0000, reg_bank[tw_addr[3:0]]};
        end
    end

    // Output generator control
    logic [1:0] mode;
    logic halt_q;
    logic gen_active;
    logic gen_active_q;
    logic start_event;
    logic [7:0] phase_offset;
    logic [7:0] target_pos;

    assign mode = reg_bank[`REG_STARTUP_ADDR][`MODE_MSB:`MODE_LSB];
    assign phase_offset = reg_bank[`REG_INDEX_PHASE_ADDR];
    assign target_pos = 8'(sensor_position + phase_offset);
    assign gen_active = normal_operation && !halt_q;
    assign start_event = gen_active && !gen_active_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halt_q <= 1'b0;
            gen_active_q <= 1'b0;
        end else begin
            halt_q <= reg_bank[`REG_STARTUP_ADDR][`HALT_BIT];
            gen_active_q <= gen_active;
        end
    end

    logic [7:0] step_count;
    logic step_tick;

    always_ff @(posedge clk) begin
        if (!rst_n || step_tick) begin
            step_count <= 8'h00;
        end else begin
            step_count <= step_count + 8'h01;
        end
    end

    assign step_tick = (step_count == 8'(STEP_CYCLES - 1));

    // Output position walks one step per tick toward the target, shortest way round
    logic [7:0] out_pos;
    logic [7:0] phase_base;
    logic [7:0] pos_diff;

    assign pos_diff = 8'(target_pos - out_pos);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_pos <= 8'h00;
            phase_base <= 8'h00;
        end else if (start_event) begin
            unique case (mode)
                `MODE_ABSOLUTE: begin
                    out_pos <= target_pos;
                    phase_base <= 8'h00;
                end
                `MODE_BURST: begin
                    out_pos <= 8'h00;
                    phase_base <= 8'h00;
                end
                `MODE_RELATIVE, `MODE_RESERVED: begin
                    out_pos <= target_pos;
                    phase_base <= target_pos;
                end
            endcase
        end else if (gen_active && step_tick && pos_diff != 8'h00) begin
            out_pos <= pos_diff[7] ? 8'(out_pos - 8'h01) : 8'(out_pos + 8'h01);
        end
    end

    logic [7:0] run_phase;
    logic [7:0] show_phase;
    logic show_ab;

    assign run_phase = 8'(out_pos - phase_base);
    // The start cycle shows the mode's first phase, not the position left over from the last run
    assign show_phase = !gen_active ? target_pos : !start_event ? run_phase
        : (mode == `MODE_ABSOLUTE) ? target_pos : 8'h00;
    // Before normal operation only absolute mode shows levels; halt blanks everything
    assign show_ab = gen_active || (!normal_operation && !halt_q && mode == `MODE_ABSOLUTE);

    always_ff @(posedge clk) begin
        if (!rst_n || !show_ab) begin
            quad_a <= 1'b0;
            quad_b <= 1'b0;
            index_z <= 1'b0;
        end else begin
            quad_a <= show_phase[1] ^ show_phase[0];
            quad_b <= show_phase[1];
            index_z <= (sensor_position == 8'h00);
        end
    end
endmodule // startup_config_and_id
`default_nettype wire

// ---- verification/startup_properties.sv ----
// Concurrent checks on the start-up block ports
`timescale 1ns/100ps
`default_nettype none
module startup_checker #(
    parameter int STARTUP_DELAY_CYCLES = 200
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic external_reset_pin_n,
    input wire logic serial_clock,
    input wire logic serial_data_line_oe,
    input wire logic [7:0] sensor_position,
    input wire logic quad_a,
    input wire logic quad_b,
    input wire logic index_z,
    input wire logic normal_operation
);
    int good_cnt;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) begin
        if (!(rst_n && supply_ok && external_reset_pin_n))
            good_cnt <= 0;
        else
            good_cnt <= good_cnt + 1;
    end
    sequence oe_up;
        $rose(serial_data_line_oe);
    endsequence
    start_delay_a: assert property ($rose(normal_operation) |-> good_cnt >= STARTUP_DELAY_CYCLES
        && good_cnt <= STARTUP_DELAY_CYCLES + 12) else $error("start delay wrong");
    supply_hold_a: assert property (!supply_ok [*6] |-> !normal_operation) else $error("supply hold");
    pin_hold_a: assert property (!external_reset_pin_n [*6] |-> !normal_operation) else $error("pin hold");
    index_zero_a: assert property ($rose(index_z) |-> $past(sensor_position) == 8'h00) else $error("index");
    step_rate_a: assert property (normal_operation && $changed({quad_a, quad_b})
        |=> $stable({quad_a, quad_b}) [*4]) else $error("step rate");
    turn_clock_a: assert property (oe_up |-> $past(serial_clock, 2)) else $error("oe rise");
    drop_clock_a: assert property ($fell(serial_data_line_oe) |-> !$past(serial_clock, 2)) else $error("oe fall");
    read_hold_a: assert property (oe_up |=> serial_data_line_oe [*8]) else $error("oe short");
    read_end_a: assert property (oe_up |-> ##[50:300] !serial_data_line_oe) else $error("oe long");
endmodule // startup_checker
bind startup_config_and_id startup_checker #(.STARTUP_DELAY_CYCLES(STARTUP_DELAY_CYCLES)) i_chk (
    .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .external_reset_pin_n(external_reset_pin_n),
    .serial_clock(serial_clock), .serial_data_line_oe(serial_data_line_oe), .sensor_position(sensor_position),
    .quad_a(quad_a), .quad_b(quad_b), .index_z(index_z), .normal_operation(normal_operation));
`default_nettype wire

// ---- verification/host_model.sv ----
// Host driving the two-wire configuration port
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic dev_out,
    input wire logic dev_oe,
    output logic sclk,
    output logic wire_level
);
    logic hd;
    logic hoe;
    initial begin
        hd = 1'b0;
        hoe = 1'b0;
        sclk = 1'b0;
    end
    // Pull-down holds the line low when nobody drives
    assign wire_level = hoe ? hd : (dev_oe ? dev_out : 1'b0);
    task automatic put_bit(input logic b);
        sclk = 1'b1;
        hd = b;
        #32 sclk = 1'b0;
        #32;
    endtask
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] bits;
        bits = {1'b1, rd, 2'b00, a, d};
        q = 8'h00;
        hoe = 1'b1;
        for (int i = 15; i >= (rd ? 8 : 0); i--) put_bit(bits[i]);
        if (rd) begin
            hoe = 1'b0;
            put_bit(1'b0);
            for (int i = 0; i < 8; i++) begin
                sclk = 1'b1;
                #32 sclk = 1'b0;
                #8 q = {q[6:0], wire_level};
                #24;
            end
            hoe = 1'b1;
        end
        put_bit(1'b0);
        hoe = 1'b0;
    endtask
endmodule // host_model
`default_nettype wire

// ---- verification/tb_startup_config_and_id.sv ----
// Testbench for the start-up and identification block
`timescale 1ns/100ps
`default_nettype none
module tb_startup_config_and_id;
    logic clk, rst_n, supply_ok, pin_n, sclk, sdl, dout, doe, qa, qb, qz, nop, ow;
    logic [7:0] pos, q, d, t;
    logic [3:0] a;
    int error_cnt, cmp_count;
    // Revision nibbles are arbitrary
    startup_config_and_id #(.MAJOR_REVISION(4'h3), .MINOR_REVISION(4'h5),
        .DEFAULT_CONFIG_WORD(32'h0000_2010), .STARTUP_DELAY_CYCLES(200)) i_dut (
        .clk(clk), .rst_n(rst_n), .external_reset_pin_n(pin_n), .supply_ok(supply_ok),
        .serial_clock(sclk), .serial_data_line_in(sdl), .serial_data_line_out(dout),
        .serial_data_line_oe(doe), .one_wire_line(ow), .sensor_position(pos),
        .quad_a(qa), .quad_b(qb), .index_z(qz), .normal_operation(nop));
    host_model i_host (.dev_out(dout), .dev_oe(doe), .sclk(sclk), .wire_level(sdl));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [1:0] ab_exp(input logic [1:0] m, input logic [7:0] tg);
        return m[1] ? {tg[1] ^ tg[0], tg[1]} : 2'b00;
    endfunction
    // One-wire frame: long high pulse is a one, short high pulse a zero
    task automatic ow_send(input logic [40:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            ow = 1'b1;
            repeat (bits[i] ? 300 : 20) @(negedge clk);
            ow = 1'b0;
            repeat (20) @(negedge clk);
        end
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        {rst_n, supply_ok, pin_n, ow} = 4'b0110;
        pos = 8'h00;
        void'($urandom(97));
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (100) @(negedge clk);
        check("early run", {7'h00, nop}, 8'h00);
        repeat (130) @(negedge clk);
        check("late run", {7'h00, nop}, 8'h01);
        i_host.xfer(1'b1, 4'h0, 8'h00, q);
        check("id", q, 8'h35);
        i_host.xfer(1'b1, 4'h1, 8'h00, q);
        check("startup", q, 8'h10);
        repeat (6) begin
            a = 4'h3 + 4'($urandom_range(12));
            d = 8'($urandom);
            i_host.xfer(1'b0, a, d, q);
            i_host.xfer(1'b1, a, 8'h00, q);
            check("reg", q, d);
        end
        d = 8'($urandom);
        ow_send({24'h00_0000, 1'b1, 3'b000, 4'h7, d, 1'b0}, 17);
        i_host.xfer(1'b1, 4'h7, 8'h00, q);
        check("one wire", q, d);
        for (int m = 0; m < 4; m++) begin
            i_host.xfer(1'b0, 4'h1, 8'h40, q);
            repeat (20) @(negedge clk);
            check("halt", {5'h00, qa, qb, qz}, 8'h00);
            pos = 8'($urandom_range(255, 1));
            i_host.xfer(1'b1, 4'h2, 8'h00, q);
            check("halted read", q, 8'h20);
            i_host.xfer(1'b0, 4'h1, {3'h0, 2'(m), 3'h0}, q);
            repeat (1400) @(negedge clk);
            t = pos + 8'h20;
            check("ab", {6'h00, qa, qb}, {6'h00, ab_exp(2'(m), t)});
        end
        pos = 8'h00;
        i_host.xfer(1'b0, 4'h1, 8'h10, q);
        repeat (1400) @(negedge clk);
        check("index", {7'h00, qz}, 8'h01);
        i_host.xfer(1'b0, 4'h1, 8'h50, q);
        ow_send({1'b1, 4'b0100, 3'h0, 32'h0000_2058, 1'b0}, 41);
        for (int k = 0; k < 2; k++) begin
            {supply_ok, pin_n} = k ? 2'b10 : 2'b01;
            repeat (10) @(negedge clk);
            check("hold", {7'h00, nop}, 8'h00);
            {supply_ok, pin_n} = 2'b11;
            repeat (230) @(negedge clk);
            i_host.xfer(1'b1, 4'h1, 8'h00, q);
            check("reload", q, 8'h58);
        end
        give_verdict();
    end
endmodule // tb_startup_config_and_id
`default_nettype wire
